// ### verilog/pwm_output_fault_and_period_control.sv
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module pwm_output_fault_and_period_control import pwm_ctrl_pkg::*; #(
    parameter int CNT_W = 16,
    parameter bit EXT_FAULT = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [3:0] i_fault,
    output logic [7:0] o_pwm,
    output logic [3:0] o_zero,
    output logic o_irq
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam int NGEN = 4;
    localparam int NOUT = 8;

    logic ack_reg;
    logic wr_en;
    logic [4:0] word_idx;
    logic [31:0] rdata_next;
    logic [CNT_W-1:0] period_prog_reg [NGEN];
    logic [CNT_W-1:0] period_act_reg [NGEN];
    logic [CNT_W-1:0] count_reg [NGEN];
    logic [NGEN-1:0] period_pend_reg;
    logic [CNT_W-1:0] width_prog_reg [NOUT];
    logic [CNT_W-1:0] width_act_reg [NOUT];
    logic [NOUT-1:0] width_pend_reg;
    logic [NGEN-1:0] zero_hit;
    logic [NOUT-1:0] wave;
    logic [7:0] out_enable_reg;
    logic [7:0] out_invert_reg;
    logic [7:0] fault_suppress_sel_reg;
    logic [7:0] fault_level_high_sel_reg;
    logic [7:0] int_enable_reg;
    logic [7:0] int_raw_reg;
    logic [7:0] int_masked;
    logic [7:0] int_event;
    logic [7:0] int_clear;
    logic [NGEN-1:0] fault_s1_reg;
    logic [NGEN-1:0] fault_s2_reg;
    logic [NGEN-1:0] fault_s3_reg;
    logic [NGEN-1:0] fault_reg;
    logic [NGEN-1:0] fault_prev_reg;
    logic [7:0] pwm_next;

    // Merge write data into a register under the byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // Avalon-MM slave: one wait cycle per access
    // ****************************************
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
    assign wr_en = i_avs_write & ack_reg;
    assign word_idx = i_avs_address[6:2];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
        end
    end

    always_comb begin
        rdata_next = 32'h00000000;
        if (word_idx < 5'(WIDTH_BASE_OFS[6:2])) begin
            rdata_next[CNT_W-1:0] = period_prog_reg[word_idx[1:0]];
        end else if (word_idx < 5'(OUT_ENABLE_OFS[6:2])) begin
            rdata_next[CNT_W-1:0] = width_prog_reg[3'(word_idx - 5'(WIDTH_BASE_OFS[6:2]))];
        end else begin
            unique case (word_idx)
                OUT_ENABLE_OFS[6:2]: rdata_next[7:0] = out_enable_reg;
                OUT_INVERT_OFS[6:2]: rdata_next[7:0] = out_invert_reg;
                FAULT_SUPPRESS_OFS[6:2]: rdata_next[7:0] = fault_suppress_sel_reg;
                FAULT_LEVEL_OFS[6:2]: rdata_next[7:0] = fault_level_high_sel_reg;
                INT_ENABLE_OFS[6:2]: rdata_next[7:0] = int_enable_reg;
                INT_RAW_OFS[6:2]: rdata_next[7:0] = int_raw_reg;
                INT_MASKED_OFS[6:2]: rdata_next[7:0] = int_masked;
                PENDING_OFS[6:2]: rdata_next[11:0] = {width_pend_reg, period_pend_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read && !ack_reg) begin
            o_avs_readdata <= rdata_next;
        end
    end

    // ****************************************
    // Output and interrupt control registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_enable_reg <= BYTE_RESET;
            out_invert_reg <= BYTE_RESET;
            fault_suppress_sel_reg <= BYTE_RESET;
            fault_level_high_sel_reg <= BYTE_RESET;
            int_enable_reg <= BYTE_RESET;
        end else if (wr_en && i_avs_byteenable[0]) begin
            unique case (word_idx)
                OUT_ENABLE_OFS[6:2]: out_enable_reg <= i_avs_writedata[7:0];
                OUT_INVERT_OFS[6:2]: out_invert_reg <= i_avs_writedata[7:0];
                FAULT_SUPPRESS_OFS[6:2]: fault_suppress_sel_reg <= i_avs_writedata[7:0];
                FAULT_LEVEL_OFS[6:2]: fault_level_high_sel_reg <= i_avs_writedata[7:0];
                INT_ENABLE_OFS[6:2]: int_enable_reg <= i_avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Generators: period, counter, zero pulse
    // ****************************************
    generate
        for (genvar g = 0; g < NGEN; g++) begin : gen_blk
            logic wr_period;
            logic [CNT_W-1:0] period_new;
            assign wr_period = wr_en && (word_idx == 5'(g));
            // next active period at the zero point
            assign period_new = period_pend_reg[g] ? period_prog_reg[g] : period_act_reg[g];
            // zero pulses are period ticks apart
            assign zero_hit[g] = (count_reg[g] == '0);

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    period_prog_reg[g] <= PERIOD_RESET[CNT_W-1:0];
                end else if (wr_period) begin
                    period_prog_reg[g] <= CNT_W'(merge_be(32'(period_prog_reg[g]), i_avs_writedata,
                                                          i_avs_byteenable));
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    period_pend_reg[g] <= 1'b0;
                end else if (wr_period) begin
                    period_pend_reg[g] <= 1'b1;
                end else if (zero_hit[g]) begin
                    period_pend_reg[g] <= 1'b0;
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    period_act_reg[g] <= PERIOD_RESET[CNT_W-1:0];
                    count_reg[g] <= '0;
                end else if (zero_hit[g]) begin
                    period_act_reg[g] <= period_new;
                    count_reg[g] <= (period_new == '0) ? '0 : period_new - 1'b1;
                end else begin
                    count_reg[g] <= count_reg[g] - 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_zero <= '0;
        end else begin
            o_zero <= zero_hit;
        end
    end

    // ****************************************
    // Comparators per output
    // ****************************************
    generate
        for (genvar o = 0; o < NOUT; o++) begin : out_blk
            logic wr_width;
            assign wr_width = wr_en && (word_idx == 5'(WIDTH_BASE_OFS[6:2]) + 5'(o));
            assign wave[o] = (count_reg[o/2] < width_act_reg[o]);

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    width_prog_reg[o] <= WIDTH_RESET[CNT_W-1:0];
                end else if (wr_width) begin
                    width_prog_reg[o] <= CNT_W'(merge_be(32'(width_prog_reg[o]), i_avs_writedata,
                                                         i_avs_byteenable));
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    width_pend_reg[o] <= 1'b0;
                end else if (wr_width) begin
                    width_pend_reg[o] <= 1'b1;
                end else if (zero_hit[o/2]) begin
                    width_pend_reg[o] <= 1'b0;
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    width_act_reg[o] <= WIDTH_RESET[CNT_W-1:0];
                end else if (zero_hit[o/2] && width_pend_reg[o]) begin
                    width_act_reg[o] <= width_prog_reg[o];
                end
            end
        end
    endgenerate

    // ****************************************
    // Fault input synchroniser
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_s1_reg <= '0;
            fault_s2_reg <= '0;
            fault_s3_reg <= '0;
            fault_reg <= '0;
            fault_prev_reg <= '0;
        end else begin
            fault_s1_reg <= i_fault;
            fault_s2_reg <= fault_s1_reg;
            fault_s3_reg <= fault_s2_reg;
            for (int g = 0; g < NGEN; g++) begin
                if (fault_s2_reg[g] == fault_s3_reg[g]) begin
                    fault_reg[g] <= fault_s3_reg[g];
                end
            end
            fault_prev_reg <= fault_reg;
        end
    end

    // ****************************************
    // Output stage
    // ****************************************
    always_comb begin
        for (int o = 0; o < NOUT; o++) begin
            // invert makes the output active low
            pwm_next[o] = (wave[o] & out_enable_reg[o]) ^ out_invert_reg[o];
            if (fault_reg[o/2] && fault_suppress_sel_reg[o]) begin
                // forced to fault level, low by default
                pwm_next[o] = EXT_FAULT & fault_level_high_sel_reg[o];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pwm <= '0;
        end else begin
            o_pwm <= pwm_next;
        end
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    assign int_event = {fault_reg & ~fault_prev_reg, zero_hit};
    assign int_clear = (wr_en && i_avs_byteenable[0] && word_idx == INT_RAW_OFS[6:2]) ?
                       i_avs_writedata[7:0] : 8'h00;
    assign int_masked = int_raw_reg & int_enable_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_raw_reg <= BYTE_RESET;
        end else begin
            int_raw_reg <= (int_raw_reg & ~int_clear) | int_event;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((((int_raw_reg & ~int_clear) | int_event)) & int_enable_reg);
        end
    end

endmodule

// ### verilog/pwm_ctrl_pkg.sv
//
// Contract
// - A generator's period is the number of clock ticks between two pulses on its zero signal.
// - Reading a period returns the last value written, even before it is in effect.
// - A period written while an earlier one still waits replaces it, so only the last one counts.
// - The interrupt enable register has one bit per generator and fault source; a one unmasks it.
// - Interrupt status reads in raw and masked form, both with the same eight bit positions.
// - An output with fault suppress selected is forced to its fault level while its fault is active.
// - With extended fault handling, a suppressed output is driven high in a fault if high is selected.
// - With no fault level set, or no extended fault handling, a suppressed output goes low in a fault.
// - The fault level has no effect on outputs that are not selected for suppression.
// - Each output has an invert selection that makes its waveform active low.
// - A disabled output is held in its inactive state; an enabled one shows the waveform.
// - Waiting period and pulse-width values take effect when the generator counter reaches zero.
// - Reading a pulse width returns the last value written, even before it is in effect.
package pwm_ctrl_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [6:0] PERIOD_BASE_OFS = 7'h00;
    localparam logic [6:0] WIDTH_BASE_OFS = 7'h10;
    localparam logic [6:0] OUT_ENABLE_OFS = 7'h30;
    localparam logic [6:0] OUT_INVERT_OFS = 7'h34;
    localparam logic [6:0] FAULT_SUPPRESS_OFS = 7'h38;
    localparam logic [6:0] FAULT_LEVEL_OFS = 7'h3c;
    localparam logic [6:0] INT_ENABLE_OFS = 7'h40;
    localparam logic [6:0] INT_RAW_OFS = 7'h44;
    localparam logic [6:0] INT_MASKED_OFS = 7'h48;
    localparam logic [6:0] PENDING_OFS = 7'h4c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int GEN_IRQ_POS = 0;
    localparam int FAULT_IRQ_POS = 4;
    localparam int PEND_WIDTH_POS = 4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [15:0] WIDTH_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

// ### testbench/power_stage.sv
`timescale 1ns/1ns
module power_stage (
    input wire logic i_clk,
    input wire logic [7:0] i_gate,
    input wire logic [3:0] i_trip,
    output logic [3:0] o_overcurrent = 4'h0,
    output logic [7:0] o_gate_seen = 8'h00
);
    // ****************************************
    // Leg trip flags and gate sampling
    // ****************************************
    always @(posedge i_clk) begin
        o_overcurrent <= i_trip;
        o_gate_seen <= i_gate;
    end
endmodule

// ### testbench/pwm_ctrl_sva.sv
`timescale 1ns/1ns
module pwm_ctrl_sva #(parameter bit EXT_FAULT = 1'b1) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [3:0] i_fault,
    input wire logic [7:0] o_pwm,
    input wire logic [3:0] o_zero,
    input wire logic o_irq
);
    // ****************************************
    // Shadow registers and settle counters
    // ****************************************
    logic [7:0] en_reg, inv_reg, sup_reg, lvl_reg, ie_reg, fs;
    logic [15:0] prd_reg, cnt_reg;
    logic [1:0] zs_reg;
    logic [3:0] quiet_reg, flt_reg;
    logic done;
    assign done = i_avs_write & ~o_avs_waitrequest;
    assign fs = sup_reg & {{2{i_fault[3]}}, {2{i_fault[2]}}, {2{i_fault[1]}}, {2{i_fault[0]}}};
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {en_reg, inv_reg, sup_reg, lvl_reg, ie_reg} <= '0;
        end else if (done) begin
            case (i_avs_address[6:2])
                5'h0c: en_reg <= i_avs_writedata[7:0];
                5'h0d: inv_reg <= i_avs_writedata[7:0];
                5'h0e: sup_reg <= i_avs_writedata[7:0];
                5'h0f: lvl_reg <= i_avs_writedata[7:0];
                5'h10: ie_reg <= i_avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    // Gen 0 interval is trusted only three pulses after its last write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {prd_reg, cnt_reg, zs_reg} <= '0;
        end else begin
            cnt_reg <= o_zero[0] ? 16'h0000 : cnt_reg + 16'h0001;
            if (done && i_avs_address[6:2] == 5'h00) begin
                prd_reg <= i_avs_writedata[15:0];
                zs_reg <= 2'h0;
            end else if (o_zero[0] && zs_reg != 2'h3) begin
                zs_reg <= zs_reg + 2'h1;
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {quiet_reg, flt_reg} <= '0;
        end else begin
            flt_reg <= i_fault;
            quiet_reg <= (done || flt_reg != i_fault) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_wait_first;
        $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("waitrequest low in first cycle");
    property p_wait_one;
        (i_avs_read | i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("more than one wait cycle");
    property p_unmapped;
        i_avs_read && !o_avs_waitrequest && i_avs_address >= 7'h50 |-> o_avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_period;
        o_zero[0] && zs_reg == 2'h3 |-> cnt_reg == ((prd_reg == 16'h0) ? 16'h0 : prd_reg - 16'h1);
    endproperty
    a_period: assert property (p_period) else $error("zero pulse spacing wrong");
    property p_irq_off;
        ie_reg == 8'h00 && $past(ie_reg) == 8'h00 |-> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt with all sources masked");
    property p_irq_on;
        ie_reg[0] && $past(ie_reg[0]) && o_zero[0] |-> ##[0:2] o_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("unmasked event gave no interrupt");
    property p_fault_force;
        quiet_reg >= 4'h8 |-> ((o_pwm ^ (lvl_reg & {8{EXT_FAULT}})) & fs) == 8'h00;
    endproperty
    a_fault_force: assert property (p_fault_force) else $error("suppressed pin not at level");
    property p_idle_level;
        quiet_reg >= 4'h8 |-> ((o_pwm ^ inv_reg) & ~en_reg & ~fs) == 8'h00;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("disabled pin not idle");
    c_fault: cover property (quiet_reg >= 4'h8 && fs != 8'h00);
    c_irq: cover property (o_irq);
    c_period: cover property (o_zero[0] && zs_reg == 2'h3);
endmodule
bind pwm_output_fault_and_period_control pwm_ctrl_sva #(.EXT_FAULT(EXT_FAULT)) u_sva (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_fault(i_fault), .o_pwm(o_pwm), .o_zero(o_zero), .o_irq(o_irq));

// ### testbench/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end
module testbench import pwm_ctrl_pkg::*; ;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [6:0] adr = 7'h00;
    logic [31:0] wdat = 32'h0, rdat, rv;
    logic [3:0] trip = 4'h0, t, flt, zero;
    logic [7:0] pwm, gate, gs, en, inv, sup, lvl, ie, fr;
    logic wreq, irq, irqs;
    logic [15:0] p;
    int compares = 0, miscompares = 0, n;
    pwm_output_fault_and_period_control dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_fault(flt), .o_pwm(pwm), .o_zero(zero), .o_irq(irq));
    power_stage stage (.i_clk(i_clk), .i_gate(pwm), .i_trip(trip), .o_overcurrent(flt), .o_gate_seen(gate));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    // ****************************************
    // Bus, wait and expectation helpers
    // ****************************************
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic stuck();
        miscompares++;
        $display("[ERR] wait expected done seen stuck");
        print_verdict();
    endtask
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0) stuck();
        rv = rdat;
        irqs = irq;
        @(posedge i_clk);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic settle(input int c);
        repeat (c) @(negedge i_clk);
        gs = gate;
        @(posedge i_clk);
    endtask
    task automatic wait_zero(input int g);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (zero[g] !== 1'b1 && n < 300);
        if (zero[g] !== 1'b1) stuck();
        @(posedge i_clk);
    endtask
    function automatic logic [7:0] pin(input logic [7:0] e, i, s, l, fm);
        return ((8'h55 & e) ^ i) & ~(fm & s) | (l & fm & s);
    endfunction
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(83373));
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        bus(1'b0, INT_ENABLE_OFS, 32'h0);
        `CHK("int_enable", 32'h0, rv)
        bus(1'b0, PERIOD_BASE_OFS + 7'h0c, 32'h0);
        `CHK("period", {16'h0, PERIOD_RESET}, rv)
        bus(1'b0, 7'h50, 32'h0);
        `CHK("unmapped", 32'h0, rv)
        $display("reset test done");
        for (int g = 0; g < 4; g++) begin
            bus(1'b1, PERIOD_BASE_OFS + 7'(4 * g), 32'h3c);
            wait_zero(g);
            p = 16'($urandom_range(12, 3));
            bus(1'b1, PERIOD_BASE_OFS + 7'(4 * g), 32'($urandom_range(40, 20)));
            bus(1'b1, PERIOD_BASE_OFS + 7'(4 * g), {16'h0, p});
            bus(1'b0, PERIOD_BASE_OFS + 7'(4 * g), 32'h0);
            `CHK("period", {16'h0, p}, rv)
            bus(1'b0, PENDING_OFS, 32'h0);
            `CHK("pending", 1'b1, rv[g])
            repeat (4) wait_zero(g);
            `CHK("interval", p, 16'(n))
        end
        for (int o = 0; o < 8; o++) begin
            bus(1'b1, WIDTH_BASE_OFS + 7'(4 * o), o[0] ? 32'h0 : 32'hffff);
            bus(1'b0, WIDTH_BASE_OFS + 7'(4 * o), 32'h0);
            `CHK("width", o[0] ? 32'h0 : 32'hffff, rv)
        end
        $display("period test done");
        fr = 8'h00;
        for (int k = 0; k < 6; k++) begin
            en = 8'($urandom);
            inv = 8'($urandom);
            sup = 8'($urandom);
            lvl = (k == 1) ? 8'h00 : 8'($urandom);
            t = k[0] ? (4'($urandom) | 4'h1) : 4'h0;
            bus(1'b1, OUT_ENABLE_OFS, {24'h0, en});
            bus(1'b1, OUT_INVERT_OFS, {24'h0, inv});
            bus(1'b1, FAULT_SUPPRESS_OFS, {24'h0, sup});
            bus(1'b1, FAULT_LEVEL_OFS, {24'h0, lvl});
            trip <= t;
            settle(12);
            `CHK("pins", pin(en, inv, sup, lvl, {{2{t[3]}}, {2{t[2]}}, {2{t[1]}}, {2{t[0]}}}), gs)
            fr = fr | {t, 4'h0};
        end
        $display("output test done");
        bus(1'b0, INT_RAW_OFS, 32'h0);
        `CHK("raw", {24'h0, fr | 8'h0f}, rv)
        for (int k = 0; k < 4; k++) begin
            ie = (k == 0) ? 8'h01 : 8'($urandom);
            bus(1'b1, INT_ENABLE_OFS, {24'h0, ie});
            bus(1'b0, INT_MASKED_OFS, 32'h0);
            `CHK("masked", {24'h0, (fr | 8'h0f) & ie}, rv)
            `CHK("irq", |((fr | 8'h0f) & ie), irqs)
        end
        bus(1'b1, INT_ENABLE_OFS, 32'hf0);
        bus(1'b1, INT_RAW_OFS, 32'hf0);
        bus(1'b0, INT_MASKED_OFS, 32'h0);
        `CHK("cleared", 32'h0, rv)
        `CHK("irq", 1'b0, irqs)
        $display("interrupt test done");
        print_verdict();
    end
endmodule
